// file: compat_cfg.svh
// Constants for the radio compatibility mode selector.
// Assumes one clock (pclk, 25 MHz) and an APB master with 32-bit data.
`ifndef COMPAT_CFG_SVH
`define COMPAT_CFG_SVH

`define OFF_CMD 12'h000
`define OFF_STATUS 12'h004
`define OFF_CTRL 12'h008
`define OFF_ADDR 12'h00C
`define OFF_TXDLY 12'h010
`define OFF_MSG 12'h014
`define OFF_RATE 12'h018

`define CMD_COMPAT 8'h53
`define CMD_REPEAT 8'h4D
`define ARG_REP_ON 8'h52
`define ARG_REP_OFF 8'h4F

`define CTRL_RXADDR 0
`define CTRL_TXADDR 1
`define CTRL_FEC 2
`define CTRL_BAND400 3

`define RX_ADDR_RST 16'h0000
`define TX_ADDR_RST 16'h00FF
`define BCAST_ADDR 8'hFF
`define SUPPORTED_RST 32'hFFFF_FFFF

`define PAUSE_BYTES 8'h04
`define TICKS_PER_MS 15'h61A8

`endif

// file: compat_pkg.sv
// Types for the radio compatibility mode selector.
// Assumes compat_cfg.svh supplies the numbers.
`default_nettype none
package compat_pkg;
    typedef enum logic [2:0] {
        fam_native = 3'h0,
        fam_fsk4 = 3'h1,
        fam_gmsk = 3'h2,
        fam_legacy = 3'h3,
        fam_fst = 3'h4,
        fam_survey = 3'h5,
        fam_maritime = 3'h6,
        fam_invalid = 3'h7
    } family_e;

    typedef struct packed {
        logic valid;
        family_e family;
        logic fec;
        logic scramble;
        logic wide;
        logic [4:0] index;
    } option_s;

    typedef enum logic [3:0] {
        tx_idle = 4'b0001,
        tx_collect = 4'b0010,
        tx_delay = 4'b0100,
        tx_send = 4'b1000
    } tx_state_e;
endpackage
`default_nettype wire

// file: compat_select.sv
// Command interpreter and mode logic for over-the-air compatibility selection.
// Assumes an APB master on pclk; serial-side byte events arrive on serial_byte_valid and serial_byte_tick.
`include "compat_cfg.svh"
`default_nettype none
module compat_select (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_byte_valid,
    input wire logic serial_byte_tick,
    input wire logic rx_msg_valid,
    input wire logic [7:0] rx_msg_addr,
    input wire logic rx_msg_done,
    output logic rx_accept,
    output logic rx_release,
    output logic tx_start,
    output logic [7:0] tx_dest,
    output logic [2:0] mode_family,
    output logic mode_fec,
    output logic mode_scramble,
    output logic native_fec,
    output logic repeater_on
);
    // Decimal option code to attributes; 0 invalid entry for unknown codes
    function automatic compat_pkg::option_s decode(input logic [7:0] code);
        compat_pkg::option_s o;
        o = '{valid: 1'b1, family: compat_pkg::fam_invalid, fec: 1'b0, scramble: 1'b0, wide: 1'b0, index: 5'h00};
        case (code)
            8'h00: o = '{1'b1, compat_pkg::fam_native, 1'b0, 1'b0, 1'b1, 5'h00};
            8'h01: o = '{1'b1, compat_pkg::fam_fsk4, 1'b1, 1'b1, 1'b1, 5'h01};
            8'h17: o = '{1'b1, compat_pkg::fam_fsk4, 1'b0, 1'b1, 1'b1, 5'h02};
            8'h1A: o = '{1'b1, compat_pkg::fam_fsk4, 1'b0, 1'b0, 1'b1, 5'h03};
            8'h1C: o = '{1'b1, compat_pkg::fam_fsk4, 1'b1, 1'b0, 1'b1, 5'h04};
            8'h02: o = '{1'b1, compat_pkg::fam_gmsk, 1'b1, 1'b1, 1'b1, 5'h05};
            8'h18: o = '{1'b1, compat_pkg::fam_gmsk, 1'b0, 1'b1, 1'b1, 5'h06};
            8'h1B: o = '{1'b1, compat_pkg::fam_gmsk, 1'b0, 1'b0, 1'b1, 5'h07};
            8'h1D: o = '{1'b1, compat_pkg::fam_gmsk, 1'b1, 1'b0, 1'b1, 5'h08};
            8'h03: o = '{1'b1, compat_pkg::fam_legacy, 1'b0, 1'b0, 1'b1, 5'h09};
            8'h04: o = '{1'b1, compat_pkg::fam_legacy, 1'b0, 1'b0, 1'b1, 5'h0A};
            8'h05: o = '{1'b1, compat_pkg::fam_fst, 1'b1, 1'b1, 1'b1, 5'h0B};
            8'h19: o = '{1'b1, compat_pkg::fam_fst, 1'b0, 1'b1, 1'b1, 5'h0C};
            8'h08: o = '{1'b1, compat_pkg::fam_survey, 1'b0, 1'b0, 1'b1, 5'h0D};
            8'h22: o = '{1'b1, compat_pkg::fam_maritime, 1'b1, 1'b0, 1'b1, 5'h0E};
            8'h23: o = '{1'b1, compat_pkg::fam_maritime, 1'b1, 1'b0, 1'b0, 5'h0F};
            8'h24: o = '{1'b1, compat_pkg::fam_maritime, 1'b0, 1'b0, 1'b1, 5'h10};
            8'h25: o = '{1'b1, compat_pkg::fam_maritime, 1'b0, 1'b0, 1'b0, 5'h11};
            default: o.valid = 1'b0;
        endcase
        return o;
    endfunction

    // One or two ASCII decimal digits to binary (hi used only when two is set); 8'hFF marks a bad digit
    function automatic logic [7:0] dec2(input logic [7:0] hi, input logic [7:0] lo, input logic two);
        logic [7:0] h;
        logic [7:0] l;
        h = hi - 8'h30;
        l = lo - 8'h30;
        if (l > 8'h09 || (two && h > 8'h09)) begin
            return 8'hFF;
        end
        return two ? 8'((h << 3) + (h << 1) + l) : l;
    endfunction

    logic wr_q;
    logic rd_q;
    logic [7:0] cur_code_q;
    logic [7:0] last_code_q;
    logic last_ok_q;
    logic reply_valid_q;
    logic [31:0] supported_q;
    logic [3:0] ctrl_q;
    logic [15:0] rx_addr_q;
    logic [15:0] tx_addr_q;
    logic [15:0] txdly_q;
    logic saved_fec_q;
    logic fec_forced_q;
    logic rep_q;
    logic [7:0] pause_cnt_q;
    logic [15:0] dly_ms_q;
    logic [14:0] dly_tick_q;
    logic rx_hold_q;
    compat_pkg::tx_state_e tx_st_q;
    compat_pkg::option_s cur_opt;
    compat_pkg::option_s req_opt;
    logic [7:0] req_code;
    logic access;
    logic buffered_mode;

    assign access = psel & penable;
    assign req_code = dec2(pwdata[15:8], pwdata[7:0], pwdata[16]);
    assign req_opt = decode(req_code);
    assign cur_opt = decode(cur_code_q);
    assign buffered_mode = (cur_opt.family == compat_pkg::fam_fsk4) | (cur_opt.family == compat_pkg::fam_gmsk)
                         | (cur_opt.family == compat_pkg::fam_legacy);

    // Zero-wait slave: every access completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `OFF_RATE);
        end
    end

    assign wr_q = access & pready & pwrite;
    assign rd_q = access & pready & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_code_q <= 8'h00;
            last_code_q <= 8'h00;
            last_ok_q <= 1'b0;
            reply_valid_q <= 1'b0;
        end else if (wr_q && paddr == `OFF_CMD && pwdata[31:24] == `CMD_COMPAT) begin
            last_code_q <= req_code;
            reply_valid_q <= 1'b1;
            if (req_opt.valid && supported_q[req_opt.index] && ctrl_q[`CTRL_BAND400]) begin
                cur_code_q <= req_code;
                last_ok_q <= 1'b1;
            end else begin
                last_ok_q <= 1'b0;
            end
        end else if (rd_q && paddr == `OFF_STATUS) begin
            reply_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_q <= 1'b0;
        end else if (wr_q && paddr == `OFF_CMD && pwdata[31:24] == `CMD_REPEAT) begin
            if (pwdata[7:0] == `ARG_REP_ON) begin
                rep_q <= 1'b1;
            end else if (pwdata[7:0] == `ARG_REP_OFF) begin
                rep_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 4'h8;
            rx_addr_q <= `RX_ADDR_RST;
            tx_addr_q <= `TX_ADDR_RST;
            txdly_q <= 16'h0000;
            supported_q <= `SUPPORTED_RST;
        end else if (wr_q) begin
            case (paddr)
                `OFF_CTRL: ctrl_q <= pwdata[3:0];
                `OFF_ADDR: begin
                    rx_addr_q <= pwdata[15:0];
                    tx_addr_q <= pwdata[31:16];
                end
                `OFF_TXDLY: txdly_q <= pwdata[15:0];
                `OFF_RATE: supported_q <= pwdata;
                default: ;
            endcase
        end
    end

    // forced native FEC off in option 3, restored on leaving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            saved_fec_q <= 1'b0;
            fec_forced_q <= 1'b0;
        end else if (!fec_forced_q && cur_code_q == 8'h03 && ctrl_q[`CTRL_FEC]) begin
            fec_forced_q <= 1'b1;
            saved_fec_q <= 1'b1;
        end else if (fec_forced_q && cur_code_q != 8'h03) begin
            fec_forced_q <= 1'b0;
        end
    end

    // transmit framing: buffered modes collect until pause, then delay, then start; other modes go straight to delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q <= compat_pkg::tx_idle;
            pause_cnt_q <= 8'h00;
            dly_ms_q <= 16'h0000;
            dly_tick_q <= 15'h0000;
            tx_start <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            case (tx_st_q)
                compat_pkg::tx_idle: begin
                    if (serial_byte_valid) begin
                        pause_cnt_q <= 8'h00;
                        tx_st_q <= buffered_mode ? compat_pkg::tx_collect : compat_pkg::tx_delay;
                        dly_ms_q <= 16'h0000;
                        dly_tick_q <= 15'h0000;
                    end
                end
                compat_pkg::tx_collect: begin
                    if (serial_byte_valid) begin
                        pause_cnt_q <= 8'h00;
                    end else if (serial_byte_tick) begin
                        if (pause_cnt_q + 8'h01 >= `PAUSE_BYTES) begin
                            tx_st_q <= compat_pkg::tx_delay;
                        end
                        pause_cnt_q <= pause_cnt_q + 8'h01;
                    end
                end
                compat_pkg::tx_delay: begin
                    if (dly_ms_q >= txdly_q) begin
                        tx_st_q <= compat_pkg::tx_send;
                    end else if (dly_tick_q == `TICKS_PER_MS - 15'h0001) begin
                        dly_tick_q <= 15'h0000;
                        dly_ms_q <= dly_ms_q + 16'h0001;
                    end else begin
                        dly_tick_q <= dly_tick_q + 15'h0001;
                    end
                end
                compat_pkg::tx_send: begin
                    tx_start <= 1'b1;
                    tx_st_q <= compat_pkg::tx_idle;
                end
                default: tx_st_q <= compat_pkg::tx_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_accept <= 1'b0;
            rx_release <= 1'b0;
            rx_hold_q <= 1'b0;
        end else begin
            rx_accept <= rx_msg_valid & (~ctrl_q[`CTRL_RXADDR] | rx_msg_addr == rx_addr_q[7:0]
                         | rx_msg_addr == `BCAST_ADDR);
            if (rx_msg_valid) begin
                rx_hold_q <= ~ctrl_q[`CTRL_RXADDR] | rx_msg_addr == rx_addr_q[7:0] | rx_msg_addr == `BCAST_ADDR;
            end
            rx_release <= rx_hold_q & rx_msg_done & (buffered_mode | ~rx_msg_valid);
            if (rx_msg_done) begin
                rx_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dest <= `BCAST_ADDR;
            mode_family <= 3'h0;
            mode_fec <= 1'b0;
            mode_scramble <= 1'b0;
            native_fec <= 1'b0;
            repeater_on <= 1'b0;
        end else begin
            tx_dest <= ctrl_q[`CTRL_TXADDR] ? tx_addr_q[7:0] : `BCAST_ADDR;
            mode_family <= cur_opt.family;
            mode_fec <= cur_opt.fec;
            mode_scramble <= cur_opt.scramble;
            native_fec <= ctrl_q[`CTRL_FEC] & ~fec_forced_q;
            repeater_on <= rep_q;
        end
    end

    // symbol and raw rates in bps
    logic [15:0] sym_rate;
    always_comb begin
        case (cur_opt.family)
            compat_pkg::fam_fsk4, compat_pkg::fam_fst: sym_rate = cur_opt.wide ? 16'd19200 : 16'd9600;
            compat_pkg::fam_gmsk, compat_pkg::fam_legacy: sym_rate = cur_opt.wide ? 16'd9600 : 16'd4800;
            default: sym_rate = 16'd0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFF_CMD: prdata <= {24'h00_0000, cur_code_q};
                `OFF_STATUS: prdata <= {20'h0_0000, reply_valid_q, last_ok_q, rep_q, fec_forced_q, last_code_q};
                `OFF_CTRL: prdata <= {28'h000_0000, ctrl_q};
                `OFF_ADDR: prdata <= {tx_addr_q, rx_addr_q};
                `OFF_TXDLY: prdata <= {16'h0000, txdly_q};
                `OFF_MSG: prdata <= {16'(sym_rate * 2 / 3), sym_rate};
                `OFF_RATE: prdata <= supported_q;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: compat_select_properties.sv
// Port-level assertions for the compatibility mode selector.
// Assumes one clock domain; bound to every compat_select instance below.
`default_nettype none
module compat_select_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_msg_valid,
    input wire logic rx_accept,
    input wire logic [7:0] tx_dest,
    input wire logic [2:0] mode_family,
    input wire logic native_fec,
    input wire logic repeater_on
);
    logic cmd_wr;
    logic any_wr;
    assign any_wr = psel && penable && pwrite;
    assign cmd_wr = any_wr && paddr == 12'h000;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no pready after setup");
    property p_one_cycle;
        pready |=> !pready;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("pready too long");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_mode;
        $changed(mode_family) |-> $past(cmd_wr, 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed without command");
    property p_legacy;
        mode_family == 3'h3 && $past(mode_family) == 3'h3 |-> !native_fec;
    endproperty
    a_legacy: assert property (p_legacy) else $error("native fec on in legacy");
    property p_repeat;
        $changed(repeater_on) |-> $past(cmd_wr, 2);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeater changed alone");
    property p_accept;
        rx_accept |-> $past(rx_msg_valid) || $past(rx_msg_valid, 2);
    endproperty
    a_accept: assert property (p_accept) else $error("accept without header");
    property p_dest;
        $changed(tx_dest) |-> $past(any_wr, 2);
    endproperty
    a_dest: assert property (p_dest) else $error("dest changed without write");
endmodule
bind compat_select compat_select_properties chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pready, .pslverr, .rx_msg_valid, .rx_accept, .tx_dest,
    .mode_family, .native_fec, .repeater_on);
`default_nettype wire

// file: host_serial_model.sv
// Host terminal model: sends a burst of serial bytes, one per byte time.
// Assumes byte times of 8 pclk cycles; ticks run while the port is powered.
`default_nettype none
module host_serial_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send,
    input wire logic [3:0] nbytes,
    output logic serial_byte_valid,
    output logic serial_byte_tick
);
    logic [2:0] div_q;
    logic [3:0] left_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 3'h0;
            left_q <= 4'h0;
        end else begin
            div_q <= div_q + 3'h1;
            if (send)
                left_q <= nbytes;
            else if (serial_byte_tick && left_q != 4'h0)
                left_q <= left_q - 4'h1;
        end
    end
    assign serial_byte_tick = div_q == 3'h7;
    assign serial_byte_valid = serial_byte_tick && left_q != 4'h0;
endmodule
`default_nettype wire

// file: tb_radio_compat_mode_select.sv
// Bench for compat_select: option table loop, then corner cases by hand.
// Assumes APB answers on its own; a host model supplies serial bytes.
`include "compat_cfg.svh"
`default_nettype none
module tb_radio_compat_mode_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic rx_msg_valid = 1'b0;
    logic [7:0] rx_msg_addr = 8'h00;
    logic rx_msg_done = 1'b0;
    logic send = 1'b0;
    logic [3:0] nbytes = 4'h3;
    logic [31:0] prdata, r;
    logic [7:0] tx_dest;
    logic [2:0] mode_family;
    logic pready, pslverr, serial_byte_valid, serial_byte_tick, rx_accept, rx_release, tx_start;
    logic mode_fec, mode_scramble, native_fec, repeater_on, serr, seen;
    int errors = 0;
    int check_count = 0;
    int n;
    // Code, family, check-fec, fec, check-scramble, scramble
    logic [15:0] rows [18] = '{
        16'h0000, // native
        16'h011F, 16'h171B, 16'h1A1A, 16'h1C1E, // four-level
        16'h022F, 16'h182B, 16'h1B2A, 16'h1D2E, // gmsk
        16'h0330, 16'h0430, // legacy
        16'h054F, 16'h194B, // fast timing
        16'h0850, // survey
        16'h226C, 16'h236C, 16'h2468, 16'h2568 // maritime
    };
    compat_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .serial_byte_valid, .serial_byte_tick, .rx_msg_valid,
        .rx_msg_addr, .rx_msg_done, .rx_accept, .rx_release, .tx_start, .tx_dest,
        .mode_family, .mode_fec, .mode_scramble, .native_fec, .repeater_on);
    host_serial_model host (.pclk, .presetn, .send, .nbytes, .serial_byte_valid,
        .serial_byte_tick);
    always #20 pclk = ~pclk;
    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20)
            errors++;
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sel(input logic [7:0] c);
        logic [7:0] t;
        t = c / 8'h0A;
        apb(1'b1, `OFF_CMD, {`CMD_COMPAT, 7'h00, t != 8'h00, 8'h30 + t, 8'h30 + c % 8'h0A});
        // Code lands at the write edge, mode outputs one edge later
        repeat (2) @(posedge pclk);
    endtask
    task automatic rxmsg(input logic [7:0] a, input logic acc);
        seen = 1'b0;
        rx_msg_addr <= a;
        rx_msg_valid <= 1'b1;
        @(posedge pclk);
        rx_msg_valid <= 1'b0;
        repeat (4) begin
            @(posedge pclk);
            seen |= rx_accept === 1'b1;
            chk("early release", 32'h0, 32'(rx_release));
        end
        chk("accept", 32'(acc), 32'(seen));
    endtask
    task automatic txrun(input int lo, input int hi);
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        n = 0;
        while (tx_start !== 1'b1 && n < hi) begin
            @(posedge pclk);
            n++;
        end
        chk("tx gap", 32'h1, 32'(n >= lo && n < hi));
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("tx_dest", 32'hFF, 32'(tx_dest));
        chk("family", 32'h0, 32'(mode_family));
        apb(1'b0, `OFF_ADDR, 32'h0);
        chk("addr", 32'h00FF_0000, r);
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped", 32'h1, 32'(serr));
        // each row keeps one fec and scramble pairing
        foreach (rows[i]) begin
            sel(rows[i][15:8]);
            chk("family", 32'(rows[i][6:4]), 32'(mode_family));
            if (rows[i][3])
                chk("fec", 32'(rows[i][2]), 32'(mode_fec));
            if (rows[i][1])
                chk("scramble", 32'(rows[i][0]), 32'(mode_scramble));
            apb(1'b0, `OFF_CMD, 32'h0);
            chk("code", 32'(rows[i][15:8]), 32'(r[7:0]));
            apb(1'b0, `OFF_STATUS, 32'h0);
            chk("ok", 32'h1, 32'(r[10]));
        end
        sel(8'h09);
        chk("family", 32'h6, 32'(mode_family));
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk("error", 32'h0, 32'(r[10]));
        apb(1'b1, `OFF_CTRL, 32'h0);
        sel(8'h01);
        chk("family", 32'h6, 32'(mode_family));
        apb(1'b1, `OFF_CTRL, 32'hC); // addressing off
        sel(8'h03);
        // Forcing takes one more edge than the mode itself
        @(posedge pclk);
        chk("native_fec", 32'h0, 32'(native_fec));
        sel(8'h01);
        @(posedge pclk);
        chk("native_fec", 32'h1, 32'(native_fec));
        apb(1'b1, `OFF_CMD, {`CMD_REPEAT, 16'h0, `ARG_REP_ON});
        repeat (2) @(posedge pclk);
        chk("repeater", 32'h1, 32'(repeater_on));
        apb(1'b1, `OFF_CMD, {`CMD_REPEAT, 16'h0, `ARG_REP_OFF});
        repeat (2) @(posedge pclk);
        chk("repeater", 32'h0, 32'(repeater_on));
        apb(1'b1, `OFF_ADDR, 32'h0012_0005);
        // addressing on, native fec bit off
        apb(1'b1, `OFF_CTRL, 32'hB);
        repeat (2) @(posedge pclk);
        chk("tx_dest", 32'h12, 32'(tx_dest));
        apb(1'b0, `OFF_MSG, 32'h0);
        chk("rates", 32'h3200_4B00, r);
        rxmsg(8'h05, 1'b1);
        rxmsg(8'h07, 1'b0);
        rxmsg(8'hFF, 1'b1);
        rx_msg_done <= 1'b1;
        @(posedge pclk);
        rx_msg_done <= 1'b0;
        n = 0;
        while (rx_release !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
        end
        chk("release", 32'h1, 32'(rx_release));
        txrun(40, 120);
        apb(1'b1, `OFF_TXDLY, 32'h1);
        txrun(25040, 25120);
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
